//--- src/link_param_pkg.sv
// Offsets, field positions and fixed values of the link parameter bank
package link_param_pkg;
    localparam logic [12:0] ADDR_LINK_CONTROL   = 13'h0060;
    localparam logic [12:0] ADDR_REPEAT_COUNT   = 13'h0063;
    localparam logic [12:0] ADDR_DEVICE_ID      = 13'h0064;
    localparam logic [12:0] ADDR_BANK_ID        = 13'h0065;
    localparam logic [12:0] ADDR_LANE0_ID       = 13'h0066;
    localparam logic [12:0] ADDR_LANE1_ID       = 13'h0067;
    localparam logic [12:0] ADDR_SCR_LANES      = 13'h006E;
    localparam logic [12:0] ADDR_OCTETS         = 13'h006F;
    localparam logic [12:0] ADDR_FRAMES_MF      = 13'h0070;
    localparam logic [12:0] ADDR_CONVERTERS     = 13'h0071;
    localparam logic [12:0] ADDR_RES_CTRL       = 13'h0072;
    localparam logic [12:0] ADDR_TOTAL_BITS     = 13'h0073;
    localparam logic [12:0] ADDR_SAMPLES        = 13'h0074;
    localparam logic [12:0] ADDR_DENSITY_CW     = 13'h0075;
    localparam logic [12:0] ADDR_SPARE_ONE      = 13'h0076;
    localparam logic [12:0] ADDR_SPARE_TWO      = 13'h0077;
    localparam logic [12:0] ADDR_LANE0_CHECKSUM = 13'h0078;
    localparam logic [12:0] ADDR_LANE1_CHECKSUM = 13'h0079;

    // Field positions
    localparam int POWERDOWN_BIT  = 0;
    localparam int ILAS_MODE_LSB  = 2;
    localparam int SCRAMBLER_BIT  = 7;
    localparam int LANES_BIT      = 0;
    localparam int CONVERTERS_BIT = 0;
    localparam int CS_LSB         = 6;

    // Alignment sequence modes
    localparam logic [1:0] ILAS_OFF        = 2'h0;
    localparam logic [1:0] ILAS_ONCE       = 2'h1;
    localparam logic [1:0] ILAS_CONTINUOUS = 2'h3;

    // Fixed read-only values
    localparam logic [4:0] RESOLUTION_M1  = 5'h0D;
    localparam logic [4:0] TOTAL_BITS_M1  = 5'h0F;
    localparam logic [4:0] SAMPLES_M1     = 5'h00;
    localparam logic [4:0] CONTROL_WORDS  = 5'h00;
    localparam logic       HIGH_DENSITY   = 1'h0;

    // Values after reset
    localparam logic [6:0] RST_LINK_CONTROL = 7'h01;
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [4:0] RST_FIVE         = 5'h00;
    localparam logic [3:0] RST_NIBBLE       = 4'h0;
    localparam logic [1:0] RST_TWO          = 2'h0;
    localparam logic       RST_BIT          = 1'h0;

    // Serial port framing counts
    localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
    localparam logic [3:0] DATA_LAST_BIT  = 4'h7;
    localparam int         READ_FLAG_BIT  = 15;
endpackage

//--- src/serial_link_param_regs.sv
// Serial-port register bank of the link configuration parameters
//
// Notes on behaviour
// - Eight-bit repeat count for the alignment sequence; zero means sent once.
// - Repeat count applies only while the mode field selects once per sync (01); continuous mode shows zero.
// - Mode 00 off, 01 once per sync, 10 reserved, 11 continuous test.
// - Writable eight-bit device identifier reported as a link parameter.
// - Writable four-bit bank identifier in low nibble; upper nibble unused.
// - Separate writable five-bit lane identifiers for lane 0 and lane 1.
// - Bit 7 of scrambler register enables scrambling; clear means off.
// - Bit 0 of scrambler register selects one lane or two lanes.
// - Octets per frame reads as twice converters divided by lanes; not writable.
// - Only F2/M1/L1, F4/M2/L1 and F2/M2/L2 are supported.
// - Writable five-bit frames-per-multiframe in low bits; upper bits reserved.
// - Bit 0 of converters register selects primary only or both converters.
// - Control bits field: none, overrange, overflow/underflow, 11 unused.
// - Resolution minus one reads fixed 13.
// - Total bits per sample minus one reads fixed 15.
// - Samples per frame minus one reads fixed zero.
// - High density flag always reads zero and cannot be written.
// - Control words per frame field always reads zero.
// - Two freely writable spare bytes carried as reserved link fields.
// - Per-lane checksum is sum of that lane's parameters modulo 256.
`timescale 1ns/1ps
`default_nettype none

module serial_link_param_regs
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       spi_clk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_data_i,
    output logic            spi_data_o,
    output logic            spi_data_oe_o,
    output logic            link_powerdown_o,
    output logic            ilas_enable_o,
    output logic            ilas_continuous_o,
    output logic [7:0]      ilas_repeat_o,
    output logic [7:0]      device_id_o,
    output logic [3:0]      bank_id_o,
    output logic [4:0]      lane0_id_o,
    output logic [4:0]      lane1_id_o,
    output logic            scrambler_en_o,
    output logic            two_lanes_o,
    output logic [7:0]      octets_per_frame_o,
    output logic [4:0]      frames_per_multiframe_o,
    output logic            two_converters_o,
    output logic [1:0]      control_bits_o,
    output logic [7:0]      spare_one_o,
    output logic [7:0]      spare_two_o,
    output logic [7:0]      lane0_checksum_o,
    output logic [7:0]      lane1_checksum_o
);

    typedef enum logic [1:0]
    {
        PH_INSTR = 2'b01,
        PH_DATA  = 2'b10
    } phase_t;

    // Parameter storage
    logic [6:0]  link_control;
    logic [7:0]  repeat_count;
    logic [7:0]  device_id;
    logic [3:0]  bank_id;
    logic [4:0]  lane0_id;
    logic [4:0]  lane1_id;
    logic        scrambler_en;
    logic        lanes_sel;
    logic [4:0]  frames_mf;
    logic        conv_sel;
    logic [1:0]  control_bits;
    logic [7:0]  spare_one;
    logic [7:0]  spare_two;
    logic [7:0]  lane0_checksum;
    logic [7:0]  lane1_checksum;

    // Serial port state
    phase_t      phase;
    logic        spi_clk_prev;
    logic [3:0]  bit_count;
    logic [15:0] shift_in;
    logic [7:0]  shift_out;
    logic        read_op;
    logic [12:0] addr;

    // Derived parameters
    wire  [1:0]  ilas_mode   = link_control[link_param_pkg::ILAS_MODE_LSB +: 2];
    wire  [7:0]  octets      = conv_sel ? (lanes_sel ? 8'h02 : 8'h04)
                             : (lanes_sel ? 8'h01 : 8'h02);
    wire  [7:0]  octets_m1   = octets - 8'h01;
    wire  [7:0]  common_sum  = device_id + {4'h0, bank_id}
                             + {scrambler_en, 6'h00, lanes_sel}
                             + octets_m1 + {3'h0, frames_mf}
                             + {7'h00, conv_sel}
                             + {control_bits, 1'b0, link_param_pkg::RESOLUTION_M1}
                             + {3'h0, link_param_pkg::TOTAL_BITS_M1}
                             + {3'h0, link_param_pkg::SAMPLES_M1}
                             + {link_param_pkg::HIGH_DENSITY, 2'h0,
                                link_param_pkg::CONTROL_WORDS}
                             + spare_one + spare_two;
    wire  [7:0]  next_lane0_checksum = common_sum + {3'h0, lane0_id};
    wire  [7:0]  next_lane1_checksum = common_sum + {3'h0, lane1_id};

    // Serial port decoding
    wire         spi_rise   = spi_clk_i & ~spi_clk_prev;
    wire         spi_fall   = ~spi_clk_i & spi_clk_prev;
    wire [15:0]  instr_word = {shift_in[14:0], spi_data_i};
    wire [12:0]  instr_addr = instr_word[12:0];
    wire         instr_done = spi_rise && phase == PH_INSTR
                              && bit_count == link_param_pkg::INSTR_LAST_BIT;
    wire         byte_done  = spi_rise && phase == PH_DATA
                              && bit_count == link_param_pkg::DATA_LAST_BIT;
    wire [7:0]   wr_byte    = {shift_in[6:0], spi_data_i};
    wire         wr_strobe  = byte_done && !read_op;
    wire [12:0]  next_addr  = addr - 13'h0001;

    // Write enables per register
    wire we_link_control = wr_strobe && addr == link_param_pkg::ADDR_LINK_CONTROL;
    wire we_repeat       = wr_strobe && addr == link_param_pkg::ADDR_REPEAT_COUNT;
    wire we_device_id    = wr_strobe && addr == link_param_pkg::ADDR_DEVICE_ID;
    wire we_bank_id      = wr_strobe && addr == link_param_pkg::ADDR_BANK_ID;
    wire we_lane0_id     = wr_strobe && addr == link_param_pkg::ADDR_LANE0_ID;
    wire we_lane1_id     = wr_strobe && addr == link_param_pkg::ADDR_LANE1_ID;
    wire we_scr_lanes    = wr_strobe && addr == link_param_pkg::ADDR_SCR_LANES;
    wire we_frames_mf    = wr_strobe && addr == link_param_pkg::ADDR_FRAMES_MF;
    wire we_converters   = wr_strobe && addr == link_param_pkg::ADDR_CONVERTERS;
    wire we_res_ctrl     = wr_strobe && addr == link_param_pkg::ADDR_RES_CTRL;
    wire we_spare_one    = wr_strobe && addr == link_param_pkg::ADDR_SPARE_ONE;
    wire we_spare_two    = wr_strobe && addr == link_param_pkg::ADDR_SPARE_TWO;

    // Read value of one address; open bits and unmapped addresses read zero
    function automatic logic [7:0] read_value(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            link_param_pkg::ADDR_LINK_CONTROL:   v = {1'b0, link_control};
            link_param_pkg::ADDR_REPEAT_COUNT:   v = repeat_count;
            link_param_pkg::ADDR_DEVICE_ID:      v = device_id;
            link_param_pkg::ADDR_BANK_ID:        v = {4'h0, bank_id};
            link_param_pkg::ADDR_LANE0_ID:       v = {3'h0, lane0_id};
            link_param_pkg::ADDR_LANE1_ID:       v = {3'h0, lane1_id};
            link_param_pkg::ADDR_SCR_LANES:      v = {scrambler_en, 6'h00,
                                                      lanes_sel};
            link_param_pkg::ADDR_OCTETS:         v = octets;
            link_param_pkg::ADDR_FRAMES_MF:      v = {3'h0, frames_mf};
            link_param_pkg::ADDR_CONVERTERS:     v = {7'h00, conv_sel};
            link_param_pkg::ADDR_RES_CTRL:       v = {control_bits, 1'b0,
                                link_param_pkg::RESOLUTION_M1};
            link_param_pkg::ADDR_TOTAL_BITS:     v = {3'h0,
                                link_param_pkg::TOTAL_BITS_M1};
            link_param_pkg::ADDR_SAMPLES:        v = {3'h0,
                                link_param_pkg::SAMPLES_M1};
            link_param_pkg::ADDR_DENSITY_CW:     v = {
                                link_param_pkg::HIGH_DENSITY, 2'h0,
                                link_param_pkg::CONTROL_WORDS};
            link_param_pkg::ADDR_SPARE_ONE:      v = spare_one;
            link_param_pkg::ADDR_SPARE_TWO:      v = spare_two;
            link_param_pkg::ADDR_LANE0_CHECKSUM: v = lane0_checksum;
            link_param_pkg::ADDR_LANE1_CHECKSUM: v = lane1_checksum;
            default:                             v = 8'h00;
        endcase
        return v;
    endfunction

    // Serial port framing
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || spi_cs_n_i)
        begin
            phase     <= PH_INSTR;
            bit_count <= 4'h0;
            read_op   <= 1'b0;
            addr      <= 13'h0000;
        end
        else if (instr_done)
        begin
            phase     <= PH_DATA;
            bit_count <= 4'h0;
            read_op   <= instr_word[link_param_pkg::READ_FLAG_BIT];
            addr      <= instr_addr;
        end
        else if (byte_done)
        begin
            bit_count <= 4'h0;
            addr      <= next_addr;
        end
        else if (spi_rise)
        begin
            bit_count <= bit_count + 4'h1;
        end
    end

    // Shift registers and pin drive
    always_ff @(posedge mclk_i)
    begin
        spi_clk_prev <= rst_i ? 1'b0 : spi_clk_i;
        if (rst_i || spi_cs_n_i)
        begin
            shift_in      <= 16'h0000;
            shift_out     <= 8'h00;
            spi_data_o    <= 1'b0;
            spi_data_oe_o <= 1'b0;
        end
        else
        begin
            if (spi_rise)
                shift_in <= instr_word;
            if (instr_done)
                shift_out <= read_value(instr_addr);
            else if (byte_done)
                shift_out <= read_value(next_addr);
            else if (spi_fall && phase == PH_DATA && read_op)
            begin
                spi_data_o    <= shift_out[7];
                spi_data_oe_o <= 1'b1;
                shift_out     <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // Parameter registers; read-only fields have no write path
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            link_control <= link_param_pkg::RST_LINK_CONTROL;
            repeat_count <= link_param_pkg::RST_BYTE;
            device_id    <= link_param_pkg::RST_BYTE;
            bank_id      <= link_param_pkg::RST_NIBBLE;
            lane0_id     <= link_param_pkg::RST_FIVE;
            lane1_id     <= link_param_pkg::RST_FIVE;
            scrambler_en <= link_param_pkg::RST_BIT;
            lanes_sel    <= link_param_pkg::RST_BIT;
            frames_mf    <= link_param_pkg::RST_FIVE;
            conv_sel     <= link_param_pkg::RST_BIT;
            control_bits <= link_param_pkg::RST_TWO;
            spare_one    <= link_param_pkg::RST_BYTE;
            spare_two    <= link_param_pkg::RST_BYTE;
        end
        else
        begin
            if (we_link_control)
                link_control <= wr_byte[6:0];
            if (we_repeat)
                repeat_count <= wr_byte;
            if (we_device_id)
                device_id <= wr_byte;
            if (we_bank_id)
                bank_id <= wr_byte[3:0];
            if (we_lane0_id)
                lane0_id <= wr_byte[4:0];
            if (we_lane1_id)
                lane1_id <= wr_byte[4:0];
            if (we_scr_lanes)
            begin
                scrambler_en <= wr_byte[link_param_pkg::SCRAMBLER_BIT];
                lanes_sel    <= wr_byte[link_param_pkg::LANES_BIT];
            end
            if (we_frames_mf)
                frames_mf <= wr_byte[4:0];
            if (we_converters)
                conv_sel <= wr_byte[link_param_pkg::CONVERTERS_BIT];
            if (we_res_ctrl)
                control_bits <= wr_byte[link_param_pkg::CS_LSB +: 2];
            if (we_spare_one)
                spare_one <= wr_byte;
            if (we_spare_two)
                spare_two <= wr_byte;
        end
    end

    // Checksums and transmitter-facing outputs
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            lane0_checksum          <= 8'h00;
            lane1_checksum          <= 8'h00;
            link_powerdown_o        <= 1'b1;
            ilas_enable_o           <= 1'b0;
            ilas_continuous_o       <= 1'b0;
            ilas_repeat_o           <= 8'h00;
            device_id_o             <= 8'h00;
            bank_id_o               <= 4'h0;
            lane0_id_o              <= 5'h00;
            lane1_id_o              <= 5'h00;
            scrambler_en_o          <= 1'b0;
            two_lanes_o             <= 1'b0;
            octets_per_frame_o      <= 8'h02;
            frames_per_multiframe_o <= 5'h00;
            two_converters_o        <= 1'b0;
            control_bits_o          <= 2'h0;
            spare_one_o             <= 8'h00;
            spare_two_o             <= 8'h00;
            lane0_checksum_o        <= 8'h00;
            lane1_checksum_o        <= 8'h00;
        end
        else
        begin
            lane0_checksum    <= next_lane0_checksum;
            lane1_checksum    <= next_lane1_checksum;
            link_powerdown_o  <= link_control[link_param_pkg::POWERDOWN_BIT];
            ilas_enable_o     <= ilas_mode == link_param_pkg::ILAS_ONCE
                              || ilas_mode == link_param_pkg::ILAS_CONTINUOUS;
            ilas_continuous_o <= ilas_mode == link_param_pkg::ILAS_CONTINUOUS;
            ilas_repeat_o     <= ilas_mode == link_param_pkg::ILAS_ONCE
                               ? repeat_count : 8'h00;
            device_id_o             <= device_id;
            bank_id_o               <= bank_id;
            lane0_id_o              <= lane0_id;
            lane1_id_o              <= lane1_id;
            scrambler_en_o          <= scrambler_en;
            two_lanes_o             <= lanes_sel;
            octets_per_frame_o      <= octets;
            frames_per_multiframe_o <= frames_mf;
            two_converters_o        <= conv_sel;
            control_bits_o          <= control_bits;
            spare_one_o             <= spare_one;
            spare_two_o             <= spare_two;
            lane0_checksum_o        <= lane0_checksum;
            lane1_checksum_o        <= lane1_checksum;
        end
    end

endmodule

`default_nettype wire

//--- sim/link_param_checker_asserts.sv
// Port assertions for the link parameter register bank
`timescale 1ns/1ps
`default_nettype none

module link_param_checker
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       link_powerdown_o,
    input  wire logic       ilas_enable_o,
    input  wire logic       ilas_continuous_o,
    input  wire logic [7:0] ilas_repeat_o,
    input  wire logic [7:0] device_id_o,
    input  wire logic [3:0] bank_id_o,
    input  wire logic [4:0] lane0_id_o,
    input  wire logic [4:0] lane1_id_o,
    input  wire logic       scrambler_en_o,
    input  wire logic       two_lanes_o,
    input  wire logic [7:0] octets_per_frame_o,
    input  wire logic [4:0] frames_per_multiframe_o,
    input  wire logic       two_converters_o,
    input  wire logic [1:0] control_bits_o,
    input  wire logic [7:0] spare_one_o,
    input  wire logic [7:0] spare_two_o,
    input  wire logic [7:0] lane0_checksum_o,
    input  wire logic [7:0] lane1_checksum_o
);
    logic [7:0] common_sum;
    logic [7:0] sum0;
    logic [7:0] sum1;

    // Shared part of both lane sums
    assign common_sum = device_id_o + 8'(bank_id_o)
        + {scrambler_en_o, 6'h00, two_lanes_o} + octets_per_frame_o
        - 8'h01 + 8'(frames_per_multiframe_o) + 8'(two_converters_o)
        + {control_bits_o, 6'h0D} + 8'h0F + spare_one_o + spare_two_o;
    assign sum0 = common_sum + 8'(lane0_id_o);
    assign sum1 = common_sum + 8'(lane1_id_o);

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_port_idle;
        spi_cs_n_i ##1 spi_cs_n_i;
    endsequence

    sequence s_settled;
        !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3);
    endsequence

    a_octets_formula: assert property (
        octets_per_frame_o == ((two_converters_o ? 8'h04 : 8'h02)
            >> two_lanes_o))
        else $error("octets per frame differs from 2M/L");
    a_repeat_gated: assert property (
        (!ilas_enable_o || ilas_continuous_o) |-> ilas_repeat_o == 8'h00)
        else $error("repeat count shown outside single mode");
    a_mode_continuous: assert property (
        ilas_continuous_o |-> ilas_enable_o)
        else $error("continuous mode without sequence enabled");
    a_reset_state: assert property (
        $fell(rst_i) |-> link_powerdown_o && !ilas_enable_o
            && octets_per_frame_o == 8'h02 && device_id_o == 8'h00)
        else $error("outputs not at reset values");
    a_sum_lane0: assert property (
        s_settled and $stable(sum0) |-> lane0_checksum_o == sum0)
        else $error("lane 0 checksum wrong");
    a_sum_lane1: assert property (
        s_settled and $stable(sum1) |-> lane1_checksum_o == sum1)
        else $error("lane 1 checksum wrong");
    a_ids_hold: assert property (
        s_port_idle |-> $stable({device_id_o, bank_id_o, lane0_id_o,
            lane1_id_o}))
        else $error("identifier changed without a write");
    a_config_hold: assert property (
        s_port_idle |-> $stable({scrambler_en_o, two_lanes_o,
            frames_per_multiframe_o, two_converters_o, spare_one_o,
            spare_two_o, link_powerdown_o}))
        else $error("parameter changed without a write");
endmodule

bind serial_link_param_regs link_param_checker link_param_checker_inst
(
    .mclk_i, .rst_i, .spi_cs_n_i, .link_powerdown_o, .ilas_enable_o,
    .ilas_continuous_o, .ilas_repeat_o, .device_id_o, .bank_id_o,
    .lane0_id_o, .lane1_id_o, .scrambler_en_o, .two_lanes_o,
    .octets_per_frame_o, .frames_per_multiframe_o, .two_converters_o,
    .control_bits_o, .spare_one_o, .spare_two_o, .lane0_checksum_o,
    .lane1_checksum_o
);
`default_nettype wire

//--- sim/spi_host_model.sv
// Serial port host issuing single-byte register transfers
`timescale 1ns/1ps
`default_nettype none

module spi_host_model
(
    input  wire logic mclk_i,
    output logic      spi_clk_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o,
    input  wire logic spi_miso_i
);
    initial
    begin
        spi_clk_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // Instruction MSB first, then one data byte
    task automatic access(input logic rd, input logic [12:0] addr,
                          input logic [7:0] wdat, output logic [7:0] rdat);
        logic [23:0] word;
        word = {rd, 2'b00, addr, wdat};
        @(posedge mclk_i) spi_cs_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge mclk_i) spi_clk_o <= 1'b0;
            spi_mosi_o <= word[i];
            repeat (3) @(posedge mclk_i);
            @(posedge mclk_i) spi_clk_o <= 1'b1;
            if (i < 8)
                rdat[i] = spi_miso_i;
            repeat (3) @(posedge mclk_i);
        end
        @(posedge mclk_i) spi_clk_o <= 1'b0;
        spi_cs_n_o <= 1'b1;
        spi_mosi_o <= ~spi_mosi_o;
        repeat (4) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

//--- sim/serial_link_param_regs_bench.sv
// Self-checking bench of the link parameter register bank
`timescale 1ns/1ps
`default_nettype none

module serial_link_param_regs_bench;
    logic       mclk = 1'b0;
    logic       rst  = 1'b1;
    logic       spi_clk, spi_cs_n, mosi, spi_data, data_o, data_oe;
    logic       pd, ilas_en, ilas_cont, scr, two_l, two_m;
    logic [7:0] rep, device_identifier, octets, sp1, sp2, sum0, sum1;
    logic [3:0] bank_identifier;
    logic [4:0] lid0, lid1, kf;
    logic [1:0] cs;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         cycles = 0;

    always #2 mclk = ~mclk;
    assign spi_data = data_oe ? data_o : mosi;

    spi_host_model spi_host_model_inst (.mclk_i(mclk), .spi_clk_o(spi_clk),
        .spi_cs_n_o(spi_cs_n), .spi_mosi_o(mosi), .spi_miso_i(spi_data));

    serial_link_param_regs serial_link_param_regs_inst (.mclk_i(mclk),
        .rst_i(rst), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
        .spi_data_i(spi_data), .spi_data_o(data_o), .spi_data_oe_o(data_oe),
        .link_powerdown_o(pd), .ilas_enable_o(ilas_en),
        .ilas_continuous_o(ilas_cont), .ilas_repeat_o(rep),
        .device_id_o(device_identifier), .bank_id_o(bank_identifier), .lane0_id_o(lid0),
        .lane1_id_o(lid1), .scrambler_en_o(scr), .two_lanes_o(two_l),
        .octets_per_frame_o(octets), .frames_per_multiframe_o(kf),
        .two_converters_o(two_m), .control_bits_o(cs), .spare_one_o(sp1),
        .spare_two_o(sp2), .lane0_checksum_o(sum0), .lane1_checksum_o(sum1));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] unused;
        spi_host_model_inst.access(1'b0, a, d, unused);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] d;
        spi_host_model_inst.access(1'b1, a, 8'h00, d);
        chk(d, e);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic test_reset;
        chk({pd, octets[6:0]}, 8'h82);
        rd(link_param_pkg::ADDR_LINK_CONTROL, 8'h01);
        rd(link_param_pkg::ADDR_LANE0_CHECKSUM, 8'h1D);
        rd(link_param_pkg::ADDR_LANE1_CHECKSUM, 8'h1D);
        $display("test_reset done");
    endtask

    task automatic test_ids;
        logic [12:0] a [7] = '{13'h0064, 13'h0065, 13'h0066, 13'h0067,
                               13'h0070, 13'h0076, 13'h0077};
        logic [7:0]  m [7] = '{8'hFF, 8'h0F, 8'h1F, 8'h1F, 8'h1F, 8'hFF, 8'hFF};
        logic [7:0]  v [2] = '{8'hFF, 8'hA5};
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 7; i++)
                wr(a[i], v[k]);
            for (int i = 0; i < 7; i++)
                rd(a[i], v[k] & m[i]);
        end
        chk(device_identifier ^ sp1 ^ sp2, 8'hA5);
        chk({bank_identifier, 4'h0} ^ 8'(kf), 8'h55);
        chk(8'(lid0) ^ 8'(lid1), 8'h00);
        rd(13'h0068, 8'h00);
        $display("test_ids done");
    endtask

    task automatic test_config;
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                continue;
            wr(link_param_pkg::ADDR_CONVERTERS, {7'h7F, i[0]});
            wr(link_param_pkg::ADDR_SCR_LANES, {~i[0], 6'h3F, i[1]});
            rd(link_param_pkg::ADDR_SCR_LANES, {~i[0], 6'h00, i[1]});
            rd(link_param_pkg::ADDR_CONVERTERS, {7'h00, i[0]});
            rd(link_param_pkg::ADDR_OCTETS, 8'((i[0] ? 4 : 2) >> i[1]));
            chk({scr, two_l, two_m}, {~i[0], i[1], i[0]});
        end
        $display("test_config done");
    endtask

    task automatic test_fixed;
        logic [12:0] a [4] = '{13'h006F, 13'h0073, 13'h0074, 13'h0075};
        logic [7:0]  e [4] = '{8'h02, 8'h0F, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            wr(link_param_pkg::ADDR_RES_CTRL, {i[1:0], 6'h3F});
            rd(link_param_pkg::ADDR_RES_CTRL, {i[1:0], 6'h0D});
            chk(8'(cs), 8'(i[1:0]));
            wr(a[i], 8'hFF);
        end
        for (int i = 0; i < 4; i++)
            rd(a[i], e[i]);
        $display("test_fixed done");
    endtask

    task automatic test_ilas;
        wr(link_param_pkg::ADDR_REPEAT_COUNT, 8'hA7);
        for (int m = 0; m < 4; m++)
        begin
            wr(link_param_pkg::ADDR_LINK_CONTROL, {4'h0, m[1:0], 2'h1});
            chk({ilas_en, ilas_cont}, {m[0], m[1] & m[0]});
            chk(rep, (m == 1) ? 8'hA7 : 8'h00);
        end
        rd(link_param_pkg::ADDR_REPEAT_COUNT, 8'hA7);
        $display("test_ilas done");
    endtask

    task automatic test_checksum;
        logic [12:0] a [9] = '{13'h0064, 13'h0065, 13'h0066, 13'h006E,
            13'h0070, 13'h0071, 13'h0072, 13'h0076, 13'h0077};
        logic [7:0]  d [9] = '{8'h12, 8'h03, 8'h04, 8'h81, 8'h1F, 8'h01,
            8'h40, 8'hA0, 8'h70};
        logic [7:0]  s;
        s = 8'h0D + 8'h0F + 8'h01;
        for (int i = 0; i < 9; i++)
        begin
            wr(a[i], d[i]);
            s = s + d[i];
        end
        wr(link_param_pkg::ADDR_LANE1_ID, 8'h05);
        wr(link_param_pkg::ADDR_LANE0_CHECKSUM, 8'hFF);
        wr(link_param_pkg::ADDR_LANE1_CHECKSUM, 8'hFF);
        rd(link_param_pkg::ADDR_LANE0_CHECKSUM, s);
        rd(link_param_pkg::ADDR_LANE1_CHECKSUM, s + 8'h01);
        chk(sum0 ^ sum1, s ^ (s + 8'h01));
        wr(link_param_pkg::ADDR_SPARE_ONE, 8'hA1);
        rd(link_param_pkg::ADDR_LANE0_CHECKSUM, s + 8'h01);
        chk(sum1, s + 8'h02);
        $display("test_checksum done");
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        test_reset;
        test_ids;
        test_config;
        test_fixed;
        test_ilas;
        test_checksum;
        end_of_test;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
endmodule
`default_nettype wire
